// ===== remote_peer.sv
/*
  Remote serial peer: frames one received character per go pulse and
  reports it as a receive event, after a character time set by gap.
  Assumes go is a one-cycle pulse given while busy is low.
*/
`timescale 1ns/100ps
`default_nettype none
module remote_peer
  import uart_esc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic [3:0] gap,
  output logic            rx_busy,
  output var rx_event_s   rx_event
);
  // ==========================================================================
  // Character framing
  logic [3:0] cnt_ff;
  logic [1:0] kind_ff;

  // The event comes only as the frame ends, so a slow gap tests the wait.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff   <= 4'h0;
      kind_ff  <= 2'h0;
      rx_busy  <= 1'b0;
      rx_event <= '0;
    end else begin
      rx_event <= '0;
      if (go) begin
        rx_busy <= 1'b1;
        cnt_ff  <= gap;
        kind_ff <= kind;
      end else if (rx_busy && cnt_ff == 4'h0) begin
        rx_busy          <= 1'b0;
        rx_event.done    <= 1'b1;
        rx_event.xoff    <= kind_ff == 2'h1;
        rx_event.xon     <= kind_ff == 2'h2;
        rx_event.special <= kind_ff == 2'h3;
      end else if (rx_busy) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking bench for the enhanced status and control block.
  Assumes the package and the remote peer model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import uart_esc_pkg::*;
;
  // ==========================================================================
  // Signals
  logic       clk = 1'b0;
  logic       nrst, chan_soft_rst, icr_wr, go, tx_busy, rx_busy, xoff_sent, xon_sent;
  logic       loopback, dsr_n, fifo_size_select_pin, fifo_size_128, tx_clk_1x;
  logic       baud_clk_nx, rts_n_pin, dtr_n_legacy, tx_shift_empty, serial_output_idle;
  logic       inband_flow_en, rx_store_ff, special_detect_ff, tx_data_permit_ff;
  logic       xoff_req_ff, xon_req_ff, dtr_n_ff, tx_int_req_ff, rx_int_req_ff;
  logic [1:0] clock_select_out, kind;
  logic [3:0] gap;
  logic [7:0] icr_index, icr_other_rdata, ier_value, lcr_value, mcr_value, lsr_value;
  logic [7:0] tx_level, rx_level, receive_trigger_level, flow_low_threshold;
  logic [7:0] flow_high_threshold, legacy_tx_trigger, legacy_rx_trigger;
  logic [7:0] legacy_flow_low, legacy_flow_high, rdata_ff, additional_control_ff, v;
  host_req_s  host_req;
  rx_event_s  rx_event;
  int         n_fail, n_checks, seed, k, n_store, n_xon, n_xoff;

  uart_enhanced_status_control DUT (.*);
  remote_peer peer (.*);

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    n_store += rx_store_ff;
    n_xon   += xon_req_ff;
    n_xoff  += xoff_req_ff;
  end

  // ==========================================================================
  // Tasks
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    host_req = '{wr: w, rd: !w, addr: a, wdata: d};
    tick();
    host_req = '0;
    tick();
  endtask

  task automatic iwr(input logic [7:0] idx, input logic [7:0] d);
    icr_index = idx;
    host_req.wdata = d;
    icr_wr = 1'b1;
    tick();
    icr_wr = 1'b0;
    tick();
  endtask

  // Expected status built from the bench's own inputs, never from the design.
  task automatic chk_asr(input logic th, input logic rh, input logic sp);
    bus(1'b0, ADDR_IER, 8'h00);
    chk(rdata_ff, {tx_level == 8'h00 && tx_shift_empty, fifo_size_128,
        fifo_size_select_pin, sp, ~dtr_n_legacy, ~rts_n_pin, rh, th});
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask

  task automatic send(input logic [1:0] kd);
    kind = kd;
    gap = 4'($random(seed));
    go = 1'b1;
    tick();
    go = 1'b0;
    tick(20);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    tick(20000);
    n_fail++;
    close_out();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    seed = 32'h795dc829;
    {nrst, chan_soft_rst, icr_wr, go, tx_busy, xoff_sent, xon_sent, loopback} = '0;
    {dsr_n, fifo_size_select_pin, fifo_size_128, tx_clk_1x, baud_clk_nx} = '0;
    {rts_n_pin, dtr_n_legacy, tx_shift_empty, serial_output_idle, inband_flow_en} = '1;
    {clock_select_out, kind, gap, icr_index, icr_other_rdata, ier_value} = '0;
    {lcr_value, mcr_value, tx_level, rx_level, receive_trigger_level} = '0;
    {flow_low_threshold, flow_high_threshold, legacy_tx_trigger} = {8'h10, 8'h60, 8'h00};
    {legacy_rx_trigger, legacy_flow_low, legacy_flow_high} = {8'hff, 8'h01, 8'hff};
    lsr_value = 8'($random(seed));
    host_req = '0;
    tick(4);
    nrst = 1'b1;
    chk(additional_control_ff, ACR_RST);
    chk({7'h0, dtr_n_ff}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      iwr(IDX_ACR, v);
      chk(additional_control_ff, v);
      iwr(8'h05, ~v);
      chk(additional_control_ff, v);
    end
    pulse(chan_soft_rst);
    chk(additional_control_ff, ACR_RST);
    iwr(IDX_ACR, 8'h80);
    for (int i = 0; i < 4; i++) begin
      tx_level = 8'($random(seed)) & 8'h7f;
      rx_level = 8'($random(seed)) & 8'h7f;
      {fifo_size_select_pin, fifo_size_128, rts_n_pin, tx_shift_empty} = 4'($random(seed));
      if (i == 0) {tx_level, tx_shift_empty} = 9'h001;
      tick(2);
      chk_asr(1'b0, 1'b0, 1'b0);
      bus(1'b0, ADDR_LCR, 8'h00);
      chk(rdata_ff, tx_level);
      bus(1'b0, ADDR_MCR, 8'h00);
      chk(rdata_ff, rx_level);
      bus(1'b0, ADDR_MCR, 8'h00);
      chk(rdata_ff, rx_level);
    end
    {tx_level, rx_level, tx_shift_empty} = {8'h00, 8'h40, 1'b1};
    bus(1'b1, ADDR_IER, 8'hff);
    chk_asr(1'b0, 1'b0, 1'b0);
    iwr(IDX_ACR, 8'hc0);
    bus(1'b0, ADDR_LSR, 8'h00);
    chk(rdata_ff, 8'hc0);
    icr_index = 8'h05;
    icr_other_rdata = 8'($random(seed));
    bus(1'b0, ADDR_LSR, 8'h00);
    chk(rdata_ff, icr_other_rdata);
    iwr(IDX_ACR, 8'h80);
    bus(1'b0, ADDR_LSR, 8'h00);
    chk(rdata_ff, lsr_value);
    send(2'h1);
    chk_asr(1'b1, 1'b0, 1'b0);
    chk({7'h0, tx_data_permit_ff}, 8'h00);
    bus(1'b1, ADDR_IER, 8'h03);
    chk_asr(1'b1, 1'b0, 1'b0);
    bus(1'b1, ADDR_IER, 8'h02);
    chk_asr(1'b0, 1'b0, 1'b0);
    chk({7'h0, tx_data_permit_ff}, 8'h01);
    pulse(xoff_sent);
    chk_asr(1'b0, 1'b1, 1'b0);
    pulse(xon_sent);
    chk_asr(1'b0, 1'b0, 1'b0);
    pulse(xoff_sent);
    k = n_xon;
    bus(1'b1, ADDR_IER, 8'h01);
    chk_asr(1'b0, 1'b0, 1'b0);
    chk(8'(n_xon - k), 8'h01);
    send(2'h3);
    chk_asr(1'b0, 1'b0, 1'b1);
    chk_asr(1'b0, 1'b0, 1'b0);
    k = n_store;
    iwr(IDX_ACR, 8'h81);
    send(2'h0);
    send(2'h3);
    chk_asr(1'b0, 1'b0, 1'b0);
    send(2'h1);
    chk_asr(1'b1, 1'b0, 1'b0);
    pulse(chan_soft_rst);
    iwr(IDX_ACR, 8'h80);
    chk_asr(1'b0, 1'b0, 1'b0);
    send(2'h0);
    chk(8'(n_store - k), 8'h01);
    tx_busy = 1'b1;
    iwr(IDX_ACR, 8'h82);
    chk({7'h0, tx_data_permit_ff}, 8'h01);
    tx_busy = 1'b0;
    tick(2);
    chk({7'h0, tx_data_permit_ff}, 8'h00);
    iwr(IDX_ACR, 8'h84);
    dsr_n = 1'b1;
    tick(2);
    chk({7'h0, tx_data_permit_ff}, 8'h00);
    dsr_n = 1'b0;
    tick(2);
    chk({7'h0, tx_data_permit_ff}, 8'h01);
    iwr(IDX_ACR, 8'h80);
    for (int i = 0; i < 4; i++) begin
      clock_select_out = i[1] ? 2'h2 : 2'h1;
      {tx_clk_1x, baud_clk_nx} = {2{i[0]}};
      tick(2);
      chk({7'h0, dtr_n_ff}, {7'h0, i[0]});
    end
    clock_select_out = 2'h0;
    for (int i = 2; i < 4; i++) begin
      iwr(IDX_ACR, 8'h80 | 8'(i << 3));
      {tx_busy, tx_shift_empty, serial_output_idle} = 3'b100;
      tick(2);
      chk({7'h0, dtr_n_ff}, {7'h0, i[0]});
      {tx_busy, tx_shift_empty, serial_output_idle} = 3'b011;
      tick(2);
      chk({7'h0, dtr_n_ff}, {7'h0, ~i[0]});
    end
    iwr(IDX_ACR, 8'ha8);
    k = n_xoff;
    rx_level = flow_high_threshold;
    tick(2);
    chk({7'h0, dtr_n_ff}, 8'h01);
    chk(8'(n_xoff - k), 8'h01);
    loopback = 1'b1;
    bus(1'b0, ADDR_IER, 8'h00);
    chk({6'h0, rdata_ff[3:2]}, 8'h03);
    loopback = 1'b0;
    k = n_xon;
    rx_level = flow_low_threshold - 8'h01;
    tick(2);
    chk({7'h0, dtr_n_ff}, 8'h00);
    chk(8'(n_xon - k), 8'h01);
    iwr(IDX_ACR, 8'ha0);
    ier_value = 8'h03;
    v = 8'($random(seed)) % 8'd127 + 8'd1;
    iwr(IDX_TTL, v | 8'h80);
    tx_level = v - 8'h01;
    tick(2);
    chk({7'h0, tx_int_req_ff}, 8'h01);
    tx_level = v;
    tick(2);
    chk({7'h0, tx_int_req_ff}, 8'h00);
    iwr(IDX_TTL, TTL_RST);
    {tx_level, serial_output_idle} = 9'h000;
    tick(2);
    chk({7'h0, tx_int_req_ff}, 8'h00);
    {serial_output_idle, tx_shift_empty} = 2'b10;
    tick(2);
    chk({7'h0, tx_int_req_ff}, 8'h00);
    tx_shift_empty = 1'b1;
    tick(2);
    chk({7'h0, tx_int_req_ff}, 8'h01);
    {receive_trigger_level, rx_level} = {v, v};
    tick(2);
    chk({7'h0, rx_int_req_ff}, 8'h01);
    rx_level = v - 8'h01;
    tick(2);
    chk({7'h0, rx_int_req_ff}, 8'h00);
    iwr(IDX_ACR, 8'h80);
    rx_level = v;
    tick(2);
    chk({7'h0, rx_int_req_ff}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire

// ===== uart_enhanced_status_control.sv
/*
  Enhanced status and control logic of one serial channel: additional status,
  additional control, transmit trigger level, fill-level readback, terminal-ready
  pin function and threshold selection.
  Assumes the surrounding channel supplies FIFO levels, shifter state and
  received-character events synchronous to clk, and holds the other registers.
*/
// How it works
// - Receiver XOFF sets local halt; received XON, write 0 or reset clears it.
// - Sent XOFF sets remote halt; XON clears; writing 0 sends XON.
// - Upper six status bits are read-only.
// - Out-of-band bits show inverted pins, or halt state in loopback.
// - Special flag sets on stored special character, clears on status read.
// - FIFO-select bit shows the live select pin.
// - FIFO-size bit is 0 for 16 deep, 1 for 128 deep.
// - Idle bit is 1 only with transmit FIFO and shifter empty.
// - Receiver disable keeps framing, drops data, keeps flow characters.
// - Disable changes wait for the character in progress.
// - Transmitter disable holds data; flow characters still go.
// - DSR flow control blocks data while DSR input is high.
// - Clock select bits route a clock to terminal-ready, else config field.
// - Config 01: pin high at upper threshold, low below lower.
// - Config 10/11: driver enable while transmitter busy, released at idle.
// - Enhanced enable picks enhanced thresholds, else legacy ones.
// - Indexed-read bit maps indexed registers onto line status reads.
// - Status enable maps fill levels onto reads, status onto INTERRUPT_ENABLE_REGISTER.
// - Enhanced tx interrupt when level below seven-bit trigger.
// - Trigger zero interrupts only when fully empty and line idle.
// - Enhanced rx interrupt when level reaches receive trigger.
// - XOFF at high threshold, XON below low threshold.
`timescale 1ns/100ps
`default_nettype none
module uart_enhanced_status_control
  import uart_esc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       chan_soft_rst,
  input  wire host_req_s  host_req,
  input  wire logic       icr_wr,
  input  wire logic [7:0] icr_index,
  input  wire logic [7:0] icr_other_rdata,
  input  wire logic [7:0] ier_value,
  input  wire logic [7:0] lcr_value,
  input  wire logic [7:0] mcr_value,
  input  wire logic [7:0] lsr_value,
  input  wire rx_event_s  rx_event,
  input  wire logic       rx_busy,
  input  wire logic       tx_busy,
  input  wire logic [7:0] tx_level,
  input  wire logic [7:0] rx_level,
  input  wire logic       tx_shift_empty,
  input  wire logic       serial_output_idle,
  input  wire logic       xoff_sent,
  input  wire logic       xon_sent,
  input  wire logic       inband_flow_en,
  input  wire logic       loopback,
  input  wire logic       rts_n_pin,
  input  wire logic       dsr_n,
  input  wire logic       fifo_size_select_pin,
  input  wire logic       fifo_size_128,
  input  wire logic [1:0] clock_select_out,
  input  wire logic       tx_clk_1x,
  input  wire logic       baud_clk_nx,
  input  wire logic       dtr_n_legacy,
  input  wire logic [7:0] receive_trigger_level,
  input  wire logic [7:0] flow_low_threshold,
  input  wire logic [7:0] flow_high_threshold,
  input  wire logic [7:0] legacy_tx_trigger,
  input  wire logic [7:0] legacy_rx_trigger,
  input  wire logic [7:0] legacy_flow_low,
  input  wire logic [7:0] legacy_flow_high,
  output logic [7:0]      rdata_ff,
  output logic            rx_store_ff,
  output logic            special_detect_ff,
  output logic            tx_data_permit_ff,
  output logic            xoff_req_ff,
  output logic            xon_req_ff,
  output logic            dtr_n_ff,
  output logic            tx_int_req_ff,
  output logic            rx_int_req_ff,
  output logic [7:0]      additional_control_ff
);
  // ==========================================================================
  // Registers and decode
  logic [7:0] transmit_trigger_level_ff;
  logic       tx_halted_ff;
  logic       remote_halted_ff;
  logic       special_flag_ff;
  logic       rx_dis_ff;
  logic       tx_dis_ff;
  logic       flow_halt_ff;
  logic [7:0] additional_status;
  logic [7:0] nxt_rdata;
  logic [7:0] thr_tx;
  logic [7:0] thr_rx;
  logic [7:0] thr_lo;
  logic [7:0] thr_hi;
  logic       tx_idle;
  logic       asr_wr;
  logic       asr_rd;
  logic       rx_flow_char;
  logic       clr_remote;
  function automatic logic hit(input logic [2:0] a, input logic [2:0] ref_a);
    hit = (a == ref_a);
  endfunction
  assign asr_wr = host_req.wr && additional_control_ff[ACR_ASREN] && hit(host_req.addr, ADDR_IER);
  assign asr_rd = host_req.rd && additional_control_ff[ACR_ASREN] && hit(host_req.addr, ADDR_IER);
  assign clr_remote = asr_wr && !host_req.wdata[ASR_RMHLT];
  assign rx_flow_char = inband_flow_en && (rx_event.xoff || rx_event.xon);
  assign tx_idle = (tx_level == 8'h00) && tx_shift_empty;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      additional_control_ff <= ACR_RST;
      transmit_trigger_level_ff <= TTL_RST;
    end else if (chan_soft_rst) begin
      additional_control_ff <= ACR_RST;
      transmit_trigger_level_ff <= TTL_RST;
    end else if (icr_wr && icr_index == IDX_ACR) begin
      additional_control_ff <= host_req.wdata;
    end else if (icr_wr && icr_index == IDX_TTL) begin
      transmit_trigger_level_ff <= host_req.wdata & TTL_MASK;
    end
  end

  // ==========================================================================
  // Thresholds
  always_comb begin
    if (additional_control_ff[ACR_ENTRG]) begin
      thr_tx = transmit_trigger_level_ff;
      thr_rx = receive_trigger_level;
      thr_lo = flow_low_threshold;
      thr_hi = flow_high_threshold;
    end else begin
      thr_tx = legacy_tx_trigger;
      thr_rx = legacy_rx_trigger;
      thr_lo = legacy_flow_low;
      thr_hi = legacy_flow_high;
    end
  end

  // ==========================================================================
  // Status flags
  // Set beats every clear except soft reset, so an event in a write, XON or read clearing cycle survives.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_halted_ff <= 1'b0;
    end else if (chan_soft_rst) begin
      tx_halted_ff <= 1'b0;
    end else if (rx_event.done && inband_flow_en && rx_event.xoff) begin
      tx_halted_ff <= 1'b1;
    end else if ((asr_wr && !host_req.wdata[ASR_TXHLT]) ||
                 (rx_event.done && inband_flow_en && rx_event.xon)) begin
      tx_halted_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remote_halted_ff <= 1'b0;
    end else if (chan_soft_rst) begin
      remote_halted_ff <= 1'b0;
    end else if (xoff_sent) begin
      remote_halted_ff <= 1'b1;
    end else if (xon_sent || clr_remote) begin
      remote_halted_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      special_flag_ff <= 1'b0;
    end else if (chan_soft_rst) begin
      special_flag_ff <= 1'b0;
    end else if (rx_event.done && rx_event.special && !rx_dis_ff && !rx_flow_char) begin
      special_flag_ff <= 1'b1;
    end else if (asr_rd) begin
      special_flag_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Receiver and transmitter disable, data gating
  // Disables are sampled only between characters so no frame is cut short.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_dis_ff <= 1'b0;
      tx_dis_ff <= 1'b0;
    end else begin
      if (!rx_busy) begin
        rx_dis_ff <= additional_control_ff[ACR_RXDIS];
      end
      if (!tx_busy) begin
        tx_dis_ff <= additional_control_ff[ACR_TXDIS];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_store_ff <= 1'b0;
      special_detect_ff <= 1'b0;
      tx_data_permit_ff <= 1'b0;
    end else begin
      rx_store_ff <= rx_event.done && !rx_dis_ff && !rx_flow_char;
      special_detect_ff <= rx_event.done && rx_event.special && !rx_dis_ff;
      tx_data_permit_ff <= !tx_dis_ff && !tx_halted_ff &&
                           !(additional_control_ff[ACR_DSRFC] && dsr_n);
    end
  end

  // ==========================================================================
  // Receive flow control and flow characters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flow_halt_ff <= 1'b0;
    end else if (chan_soft_rst) begin
      flow_halt_ff <= 1'b0;
    end else if (rx_level >= thr_hi) begin
      flow_halt_ff <= 1'b1;
    end else if (rx_level < thr_lo) begin
      flow_halt_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xoff_req_ff <= 1'b0;
      xon_req_ff <= 1'b0;
    end else begin
      xoff_req_ff <= inband_flow_en && (rx_level >= thr_hi) && !flow_halt_ff;
      xon_req_ff <= (inband_flow_en && flow_halt_ff && (rx_level < thr_lo) &&
                     !(rx_level >= thr_hi)) || clr_remote;
    end
  end

  // ==========================================================================
  // Terminal-ready pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dtr_n_ff <= 1'b1;
    end else if (clock_select_out[0]) begin
      dtr_n_ff <= tx_clk_1x;
    end else if (clock_select_out[1]) begin
      dtr_n_ff <= baud_clk_nx;
    end else begin
      unique case (additional_control_ff[ACR_DTRHI:ACR_DTRLO])
        DTR_FLOW: dtr_n_ff <= flow_halt_ff;
        DTR_ENLO: dtr_n_ff <= tx_idle && serial_output_idle;
        DTR_ENHI: dtr_n_ff <= !(tx_idle && serial_output_idle);
        default:  dtr_n_ff <= dtr_n_legacy;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt requests
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_int_req_ff <= 1'b0;
      rx_int_req_ff <= 1'b0;
    end else begin
      if (additional_control_ff[ACR_ENTRG] && (thr_tx == 8'h00)) begin
        tx_int_req_ff <= ier_value[1] && tx_idle && serial_output_idle;
      end else begin
        tx_int_req_ff <= ier_value[1] && (tx_level < thr_tx);
      end
      rx_int_req_ff <= ier_value[0] && (rx_level >= thr_rx);
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    additional_status = {tx_idle,
                         fifo_size_128,
                         fifo_size_select_pin,
                         special_flag_ff,
                         loopback ? flow_halt_ff : !dtr_n_ff,
                         loopback ? flow_halt_ff : !rts_n_pin,
                         remote_halted_ff,
                         tx_halted_ff};
  end

  always_comb begin
    unique case (host_req.addr)
      ADDR_IER: nxt_rdata = additional_control_ff[ACR_ASREN] ? additional_status : ier_value;
      ADDR_LCR: nxt_rdata = additional_control_ff[ACR_ASREN] ? tx_level : lcr_value;
      ADDR_MCR: nxt_rdata = additional_control_ff[ACR_ASREN] ? rx_level : mcr_value;
      ADDR_LSR: begin
        if (!additional_control_ff[ACR_ICRRD]) begin
          nxt_rdata = lsr_value;
        end else if (icr_index == IDX_ACR) begin
          nxt_rdata = additional_control_ff;
        end else if (icr_index == IDX_TTL) begin
          nxt_rdata = transmit_trigger_level_ff;
        end else begin
          nxt_rdata = icr_other_rdata;
        end
      end
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (host_req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_xoff_rx;
    rx_event.done && inband_flow_en && rx_event.xoff && !chan_soft_rst;
  endsequence
  sequence s_clr_wr;
    asr_wr && !host_req.wdata[ASR_RMHLT] && !xoff_sent && !chan_soft_rst;
  endsequence
  property p_txhalt_set;
    s_xoff_rx |=> tx_halted_ff;
  endproperty
  a_txhalt_set: assert property (p_txhalt_set) else $error("xoff did not halt");
  property p_remote_clr;
    s_clr_wr |=> !remote_halted_ff && xon_req_ff;
  endproperty
  a_remote_clr: assert property (p_remote_clr) else $error("remote clear failed");
  property p_special_rd;
    (asr_rd && !rx_event.done && !chan_soft_rst) ##1 !host_req.rd
      |-> rdata_ff[4] == $past(special_flag_ff) && !special_flag_ff;
  endproperty
  a_special_rd: assert property (p_special_rd) else $error("special not cleared");
  property p_rxdis;
    rx_dis_ff && rx_event.done |=> !rx_store_ff && !special_detect_ff;
  endproperty
  a_rxdis: assert property (p_rxdis) else $error("disabled rx stored");
  property p_dis_hold;
    tx_busy && !$stable(additional_control_ff[ACR_TXDIS]) |=> $stable(tx_dis_ff);
  endproperty
  a_dis_hold: assert property (p_dis_hold) else $error("tx disable mid char");
  property p_dsr;
    additional_control_ff[ACR_DSRFC] && dsr_n |=> !tx_data_permit_ff;
  endproperty
  a_dsr: assert property (p_dsr) else $error("dsr did not block");
  property p_rs485;
    clock_select_out == 2'h0 && additional_control_ff[4:3] == DTR_ENLO && !tx_idle
      |=> !dtr_n_ff;
  endproperty
  a_rs485: assert property (p_rs485) else $error("enable not driven");
  property p_ttl_zero;
    additional_control_ff[ACR_ENTRG] && transmit_trigger_level_ff == 8'h00 && !tx_shift_empty
      |=> !tx_int_req_ff;
  endproperty
  a_ttl_zero: assert property (p_ttl_zero) else $error("zero trigger early");
  property p_rx_int;
    additional_control_ff[ACR_ENTRG] && ier_value[0] && rx_level >= receive_trigger_level
      |=> rx_int_req_ff;
  endproperty
  a_rx_int: assert property (p_rx_int) else $error("rx interrupt missing");
endmodule
`default_nettype wire

// ===== uart_esc_pkg.sv
/*
  Constants and carrier types for the enhanced status and control block.
  Assumes the host bus uses the standard three-bit channel register map.
*/
package uart_esc_pkg;
  // ==========================================================================
  // Host bus map
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  // ==========================================================================
  // Indexed control set offsets
  localparam logic [7:0] IDX_ACR  = 8'h00;
  localparam logic [7:0] IDX_TTL  = 8'h04;
  // ==========================================================================
  // Field positions
  localparam int ACR_RXDIS = 0;
  localparam int ACR_TXDIS = 1;
  localparam int ACR_DSRFC = 2;
  localparam int ACR_DTRLO = 3;
  localparam int ACR_DTRHI = 4;
  localparam int ACR_ENTRG = 5;
  localparam int ACR_ICRRD = 6;
  localparam int ACR_ASREN = 7;
  localparam int ASR_TXHLT = 0;
  localparam int ASR_RMHLT = 1;
  // ==========================================================================
  // Reset values and terminal-ready modes
  localparam logic [7:0] ACR_RST = 8'h00;
  localparam logic [7:0] TTL_RST = 8'h00;
  localparam logic [7:0] TTL_MASK = 8'h7f;
  localparam logic [1:0] DTR_FLOW = 2'h1;
  localparam logic [1:0] DTR_ENLO = 2'h2;
  localparam logic [1:0] DTR_ENHI = 2'h3;

  typedef struct packed {
    logic done;
    logic xoff;
    logic xon;
    logic special;
  } rx_event_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_s;
endpackage
